// *** esw_consts.svh ***
// Constants of the encoder status-word flag block: offsets, bit positions, reset values
`ifndef ESW_CONSTS_SVH
`define ESW_CONSTS_SVH
// Register word indices on adr_i[5:2] (one 32-bit word each, 4 channels)
`define ESW_CTRL_OFF       4'h0
`define ESW_CLEAR_OFF      4'h1
`define ESW_REFCMD_OFF     4'h2
`define ESW_WORD0_OFF      4'h4
`define ESW_ADDR_LSB       2
`define ESW_IDX_W          4
`define ESW_CH_N           4
// Status word bit positions
`define ESW_B_VALID        0
`define ESW_B_AMP_CRC      1
`define ESW_B_FREQ         3
`define ESW_B_SUPPLY       4
`define ESW_B_FAN          5
`define ESW_B_LOST         7
`define ESW_B_REF1         8
`define ESW_B_REF2         9
`define ESW_B_CODED_OK     10
`define ESW_B_REF_ERR      11
`define ESW_B_HOMING       12
`define ESW_B_LIMIT        13
`define ESW_B_ABS_ERR1     8
`define ESW_B_ABS_ERR2     9
`define ESW_B_CODE_LO      5
`define ESW_B_BUSY         10
`define ESW_B_RM           11
`define ESW_B_WARN         12
// Control register fields
`define ESW_CTRL_FAN_EN    0
`define ESW_CTRL_MODE_LO   4
// Reset values and fills
`define ESW_WORD_RST       16'h0000
`define ESW_FLAGS_RST      9'h000
`define ESW_CTRL_RST       32'h0000_0001
`define ESW_ZERO32         32'h0000_0000
`define ESW_ZERO16         16'h0000
`define ESW_BAD_DATA       32'hDEAD_0000
`endif

// *** esw_pkg.sv ***
// Types of the encoder status-word flag block
package esw_pkg;
  // Interpretation of a channel's status word
  typedef enum logic [1:0] {
    ESW_MODE_INCR   = 2'b00,
    ESW_MODE_ABS    = 2'b01,
    ESW_MODE_DATUM  = 2'b11,
    ESW_MODE_AUX    = 2'b10
  } esw_mode_type;

  // Per-channel event and live inputs from the encoder front end
  typedef struct packed {
    logic       pos_valid;
    logic       amp_low;
    logic       freq_high;
    logic       crc_err;
    logic       supply_cut;
    logic       trig_lost;
    logic       ref1_seen;
    logic       ref2_seen;
    logic       coded_ok;
    logic       coded_fail;
    logic       ref_mon_fail;
    logic       homing_input;
    logic       limit_input;
    logic       abs_err1;
    logic       abs_err2;
    logic       datum_rx;
    logic       busy_flag;
    logic       ref_mark_flag;
    logic       warning_flag;
    logic [4:0] datum_content_code;
  } esw_events_type;

  // Latched flags of one channel
  typedef struct packed {
    logic amp_crc;
    logic freq;
    logic supply;
    logic lost;
    logic ref1;
    logic ref2;
    logic coded_ok;
    logic ref_err;
    logic spare;
  } esw_flags_type;
endpackage : esw_pkg

// *** esw_status_word.sv ***
// Per-channel encoder status-word flag logic with a classic Wishbone register slave
`timescale 1ns/1ps
`include "esw_consts.svh"

// Contract
// - Valid bit only for valid, error-free position
// - Datum-valid bit reflects datum reception
// - Amplitude error latches until software clears
// - Frequency error latches until software clears
// - CRC mismatch sets CRC flag
// - Supply cutout latches supply error
// - Fan bit follows live fan fault
// - Fan bit zero without fan monitoring
// - Lost trigger latches until clear command
// - Reference saved flags set on capture
// - Coded-valid cleared by save, set on success
// - Reference error latches; save does not clear
// - Homing and limit reported live
// - Absolute error messages reported live
// - Busy, ref mark, warning copied in datum mode
// - Five content-code bits in datum mode
// - Latched flags never self-clear
// - Separate 16-bit word per channel
// - Fixed bit layout of the status word
module esw_status_word (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  // Wishbone slave
  input  wire logic                             cyc_i,
  input  wire logic                             stb_i,
  input  wire logic                             we_i,
  input  wire logic [5:0]                       adr_i,
  input  wire logic [3:0]                       sel_i,
  input  wire logic [31:0]                      dat_i,
  output logic      [31:0]                      dat_o,
  output logic                                  ack_o,
  // Encoder front end, one entry per channel
  input  wire esw_pkg::esw_events_type [`ESW_CH_N-1:0] ev_i,
  input  wire logic                             fan_fault_i,
  // Status words toward the packet builder
  output logic      [`ESW_CH_N-1:0][15:0]       status_word_o
);

  // ------------------------------------------------------------
  // Software-visible control state
  // ------------------------------------------------------------
  logic [31:0]                          ctrl_q;
  logic [`ESW_CH_N-1:0][8:0]            clr_pulse;   // Per channel clear mask, one cycle
  logic [`ESW_CH_N-1:0]                 save_pulse;  // Per channel save-reference command
  esw_pkg::esw_flags_type [`ESW_CH_N-1:0] flags_q;
  logic                                 wr_stb;
  logic [`ESW_IDX_W-1:0]                idx;

  assign idx    = adr_i[`ESW_ADDR_LSB +: `ESW_IDX_W];
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o;

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Control word: fan monitor enable and per-channel mode, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `ESW_CTRL_RST;
    end else if (wr_stb && idx == `ESW_CTRL_OFF) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          ctrl_q[b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
  end

  // Command strobes decoded from write-only registers
  always_comb begin
    for (int c = 0; c < `ESW_CH_N; c++) begin
      clr_pulse[c]  = 9'h000;
      save_pulse[c] = 1'b0;
      if (wr_stb && idx == `ESW_CLEAR_OFF && sel_i[c]) begin
        clr_pulse[c] = {1'b0, dat_i[c*8 +: 8]};
      end else if (wr_stb && idx == `ESW_REFCMD_OFF && sel_i[c]) begin
        save_pulse[c] = dat_i[c*8];
      end
    end
  end

  // ------------------------------------------------------------
  // Per-channel flag latches and word assembly
  // ------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < `ESW_CH_N; ch++) begin : g_ch
      esw_pkg::esw_events_type ev;
      esw_pkg::esw_mode_type   mode;
      logic                    fan_en;
      logic                    any_err;
      logic [15:0]             word_d;
      logic [8:0]              clr;

      assign ev     = ev_i[ch];
      assign mode   = esw_pkg::esw_mode_type'(ctrl_q[`ESW_CTRL_MODE_LO + 2*ch +: 2]);
      assign fan_en = ctrl_q[`ESW_CTRL_FAN_EN];
      assign clr    = clr_pulse[ch];

      // Each latch: set wins over clear, nothing but software clears it
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flags_q[ch] <= esw_pkg::esw_flags_type'(`ESW_FLAGS_RST);
        end else begin
          flags_q[ch].amp_crc  <= ev.amp_low || ev.crc_err || (flags_q[ch].amp_crc && !clr[0]);
          flags_q[ch].freq     <= ev.freq_high || (flags_q[ch].freq && !clr[1]);
          flags_q[ch].supply   <= ev.supply_cut || (flags_q[ch].supply && !clr[2]);
          flags_q[ch].lost     <= ev.trig_lost || (flags_q[ch].lost && !clr[3]);
          flags_q[ch].ref1     <= ev.ref1_seen || (flags_q[ch].ref1 && !clr[4] && !save_pulse[ch]);
          flags_q[ch].ref2     <= ev.ref2_seen || (flags_q[ch].ref2 && !clr[5] && !save_pulse[ch]);
          flags_q[ch].coded_ok <= ev.coded_ok || (flags_q[ch].coded_ok && !clr[6] && !save_pulse[ch]);
          flags_q[ch].ref_err  <= ev.coded_fail || ev.ref_mon_fail || (flags_q[ch].ref_err && !clr[7]);
          flags_q[ch].spare    <= 1'b0;
        end
      end

      // Live or latched amplitude, CRC, frequency or supply error, latched ref error or live absolute error makes the position invalid
      assign any_err = flags_q[ch].amp_crc || flags_q[ch].freq || flags_q[ch].supply ||
                       flags_q[ch].ref_err || ev.amp_low || ev.crc_err || ev.freq_high ||
                       ev.supply_cut || ev.abs_err1 || ev.abs_err2;

      // Word layout depends on interpretation, one word per channel
      always_comb begin
        word_d = `ESW_WORD_RST;
        case (mode)
          esw_pkg::ESW_MODE_DATUM: begin
            word_d[`ESW_B_VALID]              = ev.datum_rx;
            word_d[`ESW_B_AMP_CRC]            = flags_q[ch].amp_crc;
            word_d[`ESW_B_CODE_LO +: 5]       = ev.datum_content_code;
            word_d[`ESW_B_BUSY]               = ev.busy_flag;
            word_d[`ESW_B_RM]                 = ev.ref_mark_flag;
            word_d[`ESW_B_WARN]               = ev.warning_flag;
          end
          default: begin
            word_d[`ESW_B_VALID]   = ev.pos_valid && !any_err;
            word_d[`ESW_B_AMP_CRC] = flags_q[ch].amp_crc;
            word_d[`ESW_B_SUPPLY]  = flags_q[ch].supply;
            word_d[`ESW_B_FAN]     = fan_en && fan_fault_i;
            word_d[`ESW_B_LOST]    = flags_q[ch].lost;
            if (mode == esw_pkg::ESW_MODE_ABS) begin
              word_d[`ESW_B_ABS_ERR1] = ev.abs_err1;
              word_d[`ESW_B_ABS_ERR2] = ev.abs_err2;
            end else begin
              word_d[`ESW_B_FREQ]     = flags_q[ch].freq;
              word_d[`ESW_B_REF1]     = flags_q[ch].ref1;
              if (mode == esw_pkg::ESW_MODE_INCR) begin
                word_d[`ESW_B_REF2]     = flags_q[ch].ref2;
                word_d[`ESW_B_CODED_OK] = flags_q[ch].coded_ok;
                word_d[`ESW_B_REF_ERR]  = flags_q[ch].ref_err;
                word_d[`ESW_B_HOMING]   = ev.homing_input;
                word_d[`ESW_B_LIMIT]    = ev.limit_input;
              end
            end
          end
        endcase
      end

      // Registered word: one cycle behind its sources
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          status_word_o[ch] <= `ESW_WORD_RST;
        end else begin
          status_word_o[ch] <= word_d;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Command registers read back as zero; unmapped reads give a marker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `ESW_ZERO32;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      if (idx == `ESW_CTRL_OFF) begin
        dat_o <= ctrl_q;
      end else if (idx == `ESW_CLEAR_OFF || idx == `ESW_REFCMD_OFF) begin
        dat_o <= `ESW_ZERO32;
      end else if (idx >= `ESW_WORD0_OFF && idx < `ESW_WORD0_OFF + `ESW_IDX_W'(`ESW_CH_N)) begin
        dat_o <= {`ESW_ZERO16, status_word_o[2'(idx - `ESW_WORD0_OFF)]};
      end else begin
        dat_o <= `ESW_BAD_DATA;
      end
    end
  end

endmodule : esw_status_word

// *** esw_status_word_sva.sv ***
// Port checker of the status-word flag block, bound into it
`timescale 1ns/1ps
`include "esw_consts.svh"
module esw_status_word_sva (
  // Clock, reset and bus
  input wire logic                                  clk_i,
  input wire logic                                  rst_i,
  input wire logic                                  cyc_i,
  input wire logic                                  stb_i,
  input wire logic                                  we_i,
  input wire logic [5:0]                            adr_i,
  input wire logic [3:0]                            sel_i,
  input wire logic [31:0]                           dat_i,
  input wire logic [31:0]                           dat_o,
  input wire logic                                  ack_o,
  // Encoder side and words
  input wire esw_pkg::esw_events_type [`ESW_CH_N-1:0] ev_i,
  input wire logic                                  fan_fault_i,
  input wire logic [`ESW_CH_N-1:0][15:0]            status_word_o
);
  logic [7:0] ctl_q;
  logic       req, wr, clr1, sav1, inc1, abs0, fan_on;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request decode; a request counts only while ack is low
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i;
  assign clr1 = wr && adr_i[5:2] == 4'h1 && sel_i[1] && dat_i[9];
  assign sav1 = wr && adr_i[5:2] == 4'h2 && sel_i[1] && dat_i[8];
  assign inc1 = ctl_q[7:6] == 2'b00;
  assign abs0 = ctl_q[5:4] == 2'b01;
  assign fan_on = fan_fault_i && ctl_q[0];
  // Mirror of the mode byte, since live bits mean different things per mode
  always_ff @(posedge clk_i) begin
    if (rst_i) ctl_q <= 8'h01;
    else if (wr && adr_i[5:2] == 4'h0 && sel_i[0]) ctl_q <= dat_i[7:0];
  end
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_single: assert property (req |=> s_ack_pulse)
    else $error("ack is not a single pulse");
  a_bad_read: assert property (req && !we_i && adr_i[5:2] == 4'h3 |=> dat_o == `ESW_BAD_DATA)
    else $error("unmapped read data wrong");
  a_freq_set: assert property (ev_i[1].freq_high && inc1 |-> ##2 status_word_o[1][3])
    else $error("frequency flag not set");
  a_freq_hold: assert property (status_word_o[1][3] && inc1 && !clr1 && !$past(clr1) |=> status_word_o[1][3])
    else $error("frequency flag dropped without clear");
  a_fan_live: assert property (!$past(rst_i) && $past(inc1) |->
    status_word_o[1][5] == $past(fan_on)) else $error("fan flag wrong");
  a_home_live: assert property (!$past(rst_i) && $past(inc1) |->
    status_word_o[1][12] == $past(ev_i[1].homing_input)) else $error("homing flag wrong");
  a_abs_live: assert property ($past(abs0) |-> status_word_o[0][8] == $past(ev_i[0].abs_err1))
    else $error("absolute error flag wrong");
  a_save_clr: assert property (sav1 && inc1 && !ev_i[1].coded_ok |-> ##2 !status_word_o[1][10])
    else $error("save left coded flag set");
endmodule : esw_status_word_sva
bind esw_status_word esw_status_word_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .ev_i, .fan_fault_i, .status_word_o);

// *** esw_enc_model.sv ***
// Encoder front-end model: per-channel levels and fan fault
`timescale 1ns/1ps
`include "esw_consts.svh"
module esw_enc_model (
  // Clock and commanded levels
  input  wire logic                                  clk_i,
  input  wire esw_pkg::esw_events_type [`ESW_CH_N-1:0] lvl_i,
  input  wire logic                                  fan_i,
  // Toward the block
  output esw_pkg::esw_events_type [`ESW_CH_N-1:0]    ev_o,
  output logic                                       fan_fault_o
);
  // Quiet at time zero so the block never sees unknown events
  initial begin
    ev_o = '0;
    fan_fault_o = 1'b0;
  end
  // Outputs move just after an edge, a cycle behind the command
  always @(posedge clk_i) begin
    ev_o <= lvl_i;
    fan_fault_o <= fan_i;
  end
endmodule : esw_enc_model

// *** testbench.sv ***
// Self-checking bench of the status-word flag block
`timescale 1ns/1ps
`include "esw_consts.svh"
module testbench;
  logic                                   clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, fan = 0;
  logic [5:0]                             adr_i = '0;
  logic [3:0]                             sel_i = '0;
  logic [31:0]                            dat_i = '0, dat_o, r;
  logic                                   ack_o, fan_fault_i;
  esw_pkg::esw_events_type [`ESW_CH_N-1:0] lvl = '0, ev_i;
  logic [`ESW_CH_N-1:0][15:0]             status_word_o;
  int                                     n_fail = 0, samples_checked = 0;
  int                                     eb[9] = '{22, 21, 19, 18, 17, 16, 15, 14, 20};
  int                                     sb[9] = '{1, 3, 4, 7, 8, 9, 10, 11, 1};
  esw_enc_model u_enc (.clk_i, .lvl_i(lvl), .fan_i(fan), .ev_o(ev_i), .fan_fault_o(fan_fault_i));
  esw_status_word uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .ev_i, .fan_fault_i, .status_word_o);
  // 50 MHz clock
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One classic cycle; the request stands until ack is sampled
  task automatic wb(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    r = dat_o;
    chk("ack", 1, ack_o);
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
  endtask : wb
  task automatic rdc(input string s, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(0, a, 4'hF, 0);
    chk(s, e, r & m);
  endtask : rdc
  task automatic hit(input int c, input int b);
    lvl[c][b] <= 1'b1;
    @(posedge clk_i);
    lvl[c][b] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : hit
  task results;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdc("ctrl", 6'h00, '1, `ESW_CTRL_RST);
    rdc("word1", 6'h14, '1, 0);
    rdc("clear reg", 6'h04, '1, 0);
    rdc("unmapped", 6'h0C, '1, `ESW_BAD_DATA);
    $display("test reset done");
    // One error pending at a time, so each clear leaves only the valid bit set
    lvl[1].pos_valid <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      hit(1, eb[i]);
      repeat (20) @(posedge clk_i);
      rdc("latch", 6'h14, 32'hFFFE, 1 << sb[i]);
      if (i == 0) rdc("valid", 6'h14, 1, 0);
      wb(1, 6'h04, 4'h2, 32'h100 << (i % 8));
      rdc("cleared", 6'h14, '1, 1);
    end
    $display("test latches done");
    lvl[1].amp_low <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(1, 6'h04, 4'h2, 32'h100);
    rdc("set wins", 6'h14, 32'h2, 32'h2);
    lvl[1].amp_low <= 1'b0;
    {lvl[1].homing_input, lvl[1].limit_input} <= 2'b11;
    repeat (2) @(posedge clk_i);
    wb(1, 6'h04, 4'h2, 32'hFF00);
    rdc("live kept", 6'h14, 32'h3002, 32'h3000);
    {lvl[1].homing_input, lvl[1].limit_input} <= 2'b00;
    repeat (3) @(posedge clk_i);
    rdc("live off", 6'h14, 32'h3000, 0);
    $display("test clear done");
    hit(1, 17);
    hit(1, 15);
    hit(1, 14);
    wb(1, 6'h08, 4'h2, 32'h100);
    rdc("save", 6'h14, 32'hFFFE, 32'h800);
    wb(1, 6'h04, 4'h2, 32'h8000);
    fan <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("fan", 32'h21, status_word_o[1] & 16'h21);
    wb(1, 6'h00, 4'h1, 0);
    rdc("fan off", 6'h14, 32'h20, 0);
    fan <= 1'b0;
    $display("test save and fan done");
    wb(1, 6'h00, 4'h1, 32'h11);
    lvl[0].abs_err1 <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc("abs err1", 6'h10, 32'h300, 32'h100);
    {lvl[0].abs_err1, lvl[0].abs_err2} <= 2'b01;
    repeat (3) @(posedge clk_i);
    rdc("abs err2", 6'h10, 32'h300, 32'h200);
    wb(1, 6'h00, 4'h1, 32'h31);
    lvl[0] <= 24'h0001F5;
    repeat (3) @(posedge clk_i);
    rdc("datum", 6'h10, '1, 32'h1EA1);
    rdc("word2", 6'h18, '1, 0);
    // Auxiliary interpretation on channel 3: frequency and ref1 shown, ref2 and homing hidden
    wb(1, 6'h00, 4'h2, 32'h800);
    hit(3, 21);
    hit(3, 17);
    hit(3, 16);
    lvl[3].homing_input <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc("aux word", 6'h1C, 32'hFFFE, 32'h108);
    lvl[3].homing_input <= 1'b0;
    $display("test modes done");
    results();
  end
endmodule : testbench
